// >>> logic/bpm_pkg.sv
// Package: constants and carrier types for the backplane master bus logic
package bpm_pkg;
	// Address field positions and interrupt line counts
	localparam int ADDR_W = 20;
	localparam int LOW_ADDR_W = 16;
	localparam int UPPER_LSB = 16;
	localparam int UPPER_W = 4;
	localparam int CASC_LSB = 8;
	localparam int CASC_W = 3;
	localparam int IOEXP_BIT = 8;
	localparam int IRQ_N = 8;
	localparam int FRONT_IRQ_N = 5;
	// On-board I/O window, port 80h..A7h
	localparam logic [15:0] ONB_IO_LO = 16'h0080;
	localparam logic [15:0] ONB_IO_HI = 16'h00A7;
	// Default socket decode (1 MB space): socket 0 top 64K, socket 1 from zero
	localparam logic [19:0] SOCK0_BASE_DEF = 20'hF0000;
	localparam logic [19:0] SOCK0_MASK_DEF = 20'hF0000;
	localparam logic [19:0] SOCK1_BASE_DEF = 20'h00000;
	localparam logic [19:0] SOCK1_MASK_DEF = 20'hF8000;
	// Bus cycle timing in system clocks
	localparam int MUX_NS = 100;
	localparam int CLK_PERIOD_NS = 5;
	localparam int MUX_CYC = (MUX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MUX_CNT_W = 6;

	typedef enum logic [1:0] {CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR} cyc_kind_e;
	typedef enum logic [1:0] {CYC_NORMAL, CYC_INTA} cyc_type_e;

	// Processor-side cycle request
	typedef struct packed {
		logic [19:0] addr;
		cyc_kind_e kind;
		cyc_type_e typ;
		logic [7:0] wdata;
	} cpu_req_s;

	// Socket decode window
	typedef struct packed {
		logic [19:0] base;
		logic [19:0] mask;
	} dec_win_s;
endpackage : bpm_pkg

// >>> logic/bpm_sync.sv
// Two-flop synchroniser for a vector of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module bpm_sync #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	// First stage feeds only the second; reset to idle-high
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_ff <= '1;
			sync_ff <= '1;
		end else begin
			meta_ff <= d_i;
			sync_ff <= meta_ff;
		end
	end

	assign q_o = sync_ff;
endmodule : bpm_sync
`default_nettype wire

// >>> logic/bpm_master.sv
// Backplane master: address drive, upper-address mux, decode, reset and standby
// Notes on behaviour
// - Low sixteen address bits always driven
// - Upper address on D0-D3 at memory start
// - Memory cycles add an address phase; I/O cycles unchanged
// - I/O port addresses sixteen bits wide
// - IOEXP follows A8, low for ports 00-FF
// - Cascade address on A8-A10 during acknowledge
// - Claim ports 80h through A7h on-board
// - Sockets default restart top and zero
// - Memory-expansion select never driven
// - Standby ends on reset or interrupt
// - Supply fault asserts and holds reset
// - Supply fault blocks memory write strobe
// - Watchdog counter output can reset processor
// - Eight jumpered prioritized interrupt inputs
// - Five front-panel interrupt requests
`timescale 1ns/1ps
`default_nettype none
module bpm_master
	import bpm_pkg::*;
(
	input wire logic SYS_CLK_I,
	input wire logic RST_I,
	// Processor side
	input wire logic REQ_VALID_I,
	input wire cpu_req_s REQ_I,
	input wire logic [2:0] CASC_ADDR_I,
	input wire logic MEM_WR_N_I,
	output logic REQ_READY_O,
	output logic [7:0] RDATA_O,
	output logic DONE_O,
	// Backplane
	output logic [15:0] BP_ADDR_O,
	input wire logic [7:0] BP_DATA_I,
	output logic [7:0] BP_DATA_O,
	output logic BP_DATA_OE_O,
	output logic MCSYNC_N_O,
	output logic IOEXP_N_O,
	output logic MEMEX_OE_O,
	output logic MEM_WR_N_O,
	// Decode
	input wire dec_win_s SOCK0_WIN_I,
	input wire dec_win_s SOCK1_WIN_I,
	input wire logic REMAP_EN_I,
	output logic SOCK0_SEL_O,
	output logic SOCK1_SEL_O,
	output logic ONB_IO_SEL_O,
	// Reset, watchdog, standby
	input wire logic SUPPLY_OK_I,
	input wire logic WDOG_EN_I,
	input wire logic CNT2_OUT_I,
	input wire logic STANDBY_REQ_I,
	input wire logic SYSRESET_N_I,
	input wire logic INTRQ_N_I,
	input wire logic NMIRQ_N_I,
	output logic PBRESET_N_O,
	output logic STANDBY_O,
	// Interrupts
	input wire logic [FRONT_IRQ_N-1:0] FRONT_IRQ_I,
	input wire logic [IRQ_N-1:0][2:0] IRQ_ROUTE_I,
	input wire logic [IRQ_N-1:0] ONB_IRQ_I,
	output logic [IRQ_N-1:0] PIC_IRQ_O
);
	typedef enum {ST_IDLE, ST_MUX, ST_DATA} state_e;

	state_e state_ff, nxt_state;
	cpu_req_s req_ff;
	logic [MUX_CNT_W-1:0] cnt_ff;
	logic [2:0] casc_ff;
	logic [7:0] rdata_ff;
	logic done_ff;
	logic standby_ff;
	logic [4:0] async_s;
	logic supply_ok_s, cnt2_s, sysreset_n_s, intrq_n_s, nmirq_n_s;
	logic [FRONT_IRQ_N-1:0] front_s;
	logic [FRONT_IRQ_N-1:0] front_n_s;
	logic is_mem, is_io, is_inta;

	// Check whether an address falls in a base/mask window
	function automatic logic in_win(input logic [19:0] a, input dec_win_s w);
		in_win = ((a & w.mask) == (w.base & w.mask));
	endfunction : in_win

	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers: supply monitor, watchdog and wake pins are asynchronous
	bpm_sync #(.W(5)) u_sync_ctl (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.d_i({SUPPLY_OK_I, CNT2_OUT_I, SYSRESET_N_I, INTRQ_N_I, NMIRQ_N_I}),
		.q_o(async_s)
	);
	assign {supply_ok_s, cnt2_s, sysreset_n_s, intrq_n_s, nmirq_n_s} = async_s;

	// Fed inverted: the synchroniser resets to ones, which must read as no request
	bpm_sync #(.W(FRONT_IRQ_N)) u_sync_irq (
		.clk_i(SYS_CLK_I),
		.rst_i(RST_I),
		.d_i(~FRONT_IRQ_I),
		.q_o(front_n_s)
	);
	assign front_s = ~front_n_s;

	////////////////////////////////////////////////////////////////////////////
	// Bus cycle sequencing
	assign is_mem = (req_ff.kind == CYC_MEM_RD) || (req_ff.kind == CYC_MEM_WR);
	assign is_io = !is_mem;
	assign is_inta = (req_ff.typ == CYC_INTA);
	// Ready only when idle and not in standby or reset
	assign REQ_READY_O = (state_ff == ST_IDLE) && !standby_ff && PBRESET_N_O;

	// Memory cycles get an address phase; I/O goes straight to data
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (REQ_VALID_I && REQ_READY_O) begin
					if ((REQ_I.kind == CYC_MEM_RD) || (REQ_I.kind == CYC_MEM_WR)) begin
						nxt_state = ST_MUX;
					end else begin
						nxt_state = ST_DATA;
					end
				end
			end
			ST_MUX: begin
				if (cnt_ff == MUX_CNT_W'(MUX_CYC - 1)) begin
					nxt_state = ST_DATA;
				end
			end
			ST_DATA: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Request capture and address-phase counter
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			req_ff <= '0;
			casc_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (state_ff == ST_IDLE && REQ_VALID_I && REQ_READY_O) begin
				req_ff <= REQ_I;
				casc_ff <= CASC_ADDR_I;
			end
			cnt_ff <= (state_ff == ST_MUX) ? cnt_ff + MUX_CNT_W'(1) : '0;
		end
	end

	// Read data sampled at end of data phase
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			rdata_ff <= '0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= (state_ff == ST_DATA);
			if (state_ff == ST_DATA) begin
				rdata_ff <= BP_DATA_I;
			end
		end
	end
	assign RDATA_O = rdata_ff;
	assign DONE_O = done_ff;

	////////////////////////////////////////////////////////////////////////////
	// Backplane address and data drive
	always_comb begin
		BP_ADDR_O = req_ff.addr[LOW_ADDR_W-1:0];
		if (is_inta) begin
			BP_ADDR_O[CASC_LSB +: CASC_W] = casc_ff;
		end
	end

	// Upper bits on D3..D0 during address phase, write data afterwards
	always_comb begin
		BP_DATA_O = '0;
		BP_DATA_OE_O = 1'b0;
		if (state_ff == ST_MUX) begin
			BP_DATA_O[UPPER_W-1:0] = req_ff.addr[UPPER_LSB +: UPPER_W];
			BP_DATA_OE_O = 1'b1;
		end else if (state_ff == ST_DATA && !is_inta &&
				(req_ff.kind == CYC_MEM_WR || req_ff.kind == CYC_IO_WR)) begin
			BP_DATA_O = req_ff.wdata;
			BP_DATA_OE_O = 1'b1;
		end
	end

	// Strobe rises one cycle before the address phase ends, so the upper bits
	// still stand on D3..D0 at the rise; avoids a hold race with the data switch
	assign MCSYNC_N_O = !((state_ff == ST_MUX) && is_mem &&
		(cnt_ff != MUX_CNT_W'(MUX_CYC - 1)));
	// Low when A8 clear on an I/O cycle other than interrupt acknowledge
	assign IOEXP_N_O = !((state_ff != ST_IDLE) && is_io && !is_inta &&
		!req_ff.addr[IOEXP_BIT]);
	assign MEMEX_OE_O = 1'b0;

	////////////////////////////////////////////////////////////////////////////
	// On-board decode: jumper windows only when remap is fitted
	always_comb begin
		SOCK0_SEL_O = 1'b0;
		SOCK1_SEL_O = 1'b0;
		ONB_IO_SEL_O = 1'b0;
		if (state_ff != ST_IDLE && is_mem) begin
			SOCK0_SEL_O = REMAP_EN_I ? in_win(req_ff.addr, SOCK0_WIN_I)
				: in_win(req_ff.addr, '{SOCK0_BASE_DEF, SOCK0_MASK_DEF});
			SOCK1_SEL_O = !SOCK0_SEL_O && (REMAP_EN_I ? in_win(req_ff.addr, SOCK1_WIN_I)
				: in_win(req_ff.addr, '{SOCK1_BASE_DEF, SOCK1_MASK_DEF}));
		end
		if (state_ff != ST_IDLE && is_io && !is_inta) begin
			ONB_IO_SEL_O = (req_ff.addr[15:0] >= ONB_IO_LO) &&
				(req_ff.addr[15:0] <= ONB_IO_HI);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Reset on supply fault or watchdog timeout; write inhibit on supply fault only
	assign PBRESET_N_O = supply_ok_s && !(WDOG_EN_I && !cnt2_s);
	// Gating is on the unsynchronised path so a fault blocks at once
	assign MEM_WR_N_O = MEM_WR_N_I || !supply_ok_s || !SUPPLY_OK_I;

	// Standby entry from processor halt request; any wake pin low releases it
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I) begin
			standby_ff <= 1'b0;
		end else if (!sysreset_n_s || !intrq_n_s || !nmirq_n_s) begin
			standby_ff <= 1'b0;
		end else if (STANDBY_REQ_I && state_ff == ST_IDLE) begin
			standby_ff <= 1'b1;
		end
	end
	assign STANDBY_O = standby_ff;

	////////////////////////////////////////////////////////////////////////////
	// Interrupt routing: eight sources, each to its jumpered controller input
	always_comb begin
		logic [IRQ_N-1:0] src;
		src = ONB_IRQ_I;
		src[FRONT_IRQ_N-1:0] = src[FRONT_IRQ_N-1:0] | front_s;
		src[IRQ_N-1] = src[IRQ_N-1] | !intrq_n_s;
		PIC_IRQ_O = '0;
		for (int i = 0; i < IRQ_N; i++) begin
			PIC_IRQ_O[IRQ_ROUTE_I[i]] = PIC_IRQ_O[IRQ_ROUTE_I[i]] | src[i];
		end
	end
endmodule : bpm_master
`default_nettype wire

// >>> verification/bpm_master_properties.sv
// Checker: port relations of the backplane master
`timescale 1ns/1ps
`default_nettype none
module bpm_master_chk
	import bpm_pkg::*;
(
	input wire logic SYS_CLK_I, RST_I, REQ_VALID_I, REQ_READY_O, MCSYNC_N_O, DONE_O,
	input wire logic IOEXP_N_O, MEM_WR_N_O, BP_DATA_OE_O, ONB_IO_SEL_O, SUPPLY_OK_I,
	input wire cpu_req_s REQ_I,
	input wire logic [2:0] CASC_ADDR_I,
	input wire logic [15:0] BP_ADDR_O,
	input wire logic [7:0] BP_DATA_O
);
	default clocking @(posedge SYS_CLK_I); endclocking
	default disable iff (RST_I);
	logic acc;
	logic nrm;
	logic [5:0] low_cnt_ff;
	//////////////////////////////
	// Taken request; kind bit 1 marks an I/O cycle
	assign acc = REQ_VALID_I && REQ_READY_O;
	assign nrm = acc && REQ_I.typ == CYC_NORMAL;
	// Address phase length, so a short mux phase shows up
	always_ff @(posedge SYS_CLK_I) begin
		if (RST_I || MCSYNC_N_O) begin
			low_cnt_ff <= 6'h00;
		end else begin
			low_cnt_ff <= low_cnt_ff + 6'h01;
		end
	end
	//////////////////////////////
	property p_upper;
		acc && !REQ_I.kind[1] |=> !MCSYNC_N_O && BP_DATA_OE_O
			&& BP_DATA_O[3:0] == $past(REQ_I.addr[19:16]);
	endproperty
	a_upper: assert property (p_upper) else $error("upper bits");
	property p_len;
		$rose(MCSYNC_N_O) |-> low_cnt_ff == MUX_CYC - 1;
	endproperty
	a_len: assert property (p_len) else $error("mux length");
	property p_io;
		nrm && REQ_I.kind[1] |=> MCSYNC_N_O ##1 DONE_O;
	endproperty
	a_io: assert property (p_io) else $error("io cycle");
	property p_addr;
		nrm |=> BP_ADDR_O == $past(REQ_I.addr[15:0]);
	endproperty
	a_addr: assert property (p_addr) else $error("low address");
	property p_exp;
		nrm && REQ_I.kind[1] |=> IOEXP_N_O == $past(REQ_I.addr[8]);
	endproperty
	a_exp: assert property (p_exp) else $error("expansion line");
	property p_onb;
		nrm && REQ_I.kind[1] |=> ONB_IO_SEL_O
			== ($past(REQ_I.addr[15:0]) inside {[ONB_IO_LO:ONB_IO_HI]});
	endproperty
	a_onb: assert property (p_onb) else $error("onboard decode");
	property p_inta;
		acc && REQ_I.typ == CYC_INTA |=> BP_ADDR_O[10:8] == $past(CASC_ADDR_I);
	endproperty
	a_inta: assert property (p_inta) else $error("cascade address");
	property p_wr;
		!SUPPLY_OK_I |-> MEM_WR_N_O;
	endproperty
	a_wr: assert property (p_wr) else $error("write not blocked");
	property p_wdat;
		nrm && REQ_I.kind == CYC_IO_WR |=> BP_DATA_OE_O && BP_DATA_O == $past(REQ_I.wdata);
	endproperty
	a_wdat: assert property (p_wdat) else $error("write data");
	cover property ($rose(MCSYNC_N_O));
	cover property (nrm && REQ_I.kind[1]);
	cover property (acc && REQ_I.typ == CYC_INTA);
endmodule : bpm_master_chk
`default_nettype wire

// >>> verification/bpm_card.sv
// Backplane memory card model: latches upper address, answers reads
`timescale 1ns/1ps
`default_nettype none
module bpm_card (
	input wire logic clk_i,
	input wire logic mcsync_n_i,
	input wire logic [15:0] addr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o
);
	logic [3:0] upper_ff;
	// Tracks the low lines while strobe is low; holds what stood at the rise
	always_ff @(posedge clk_i) begin
		if (!mcsync_n_i) begin
			upper_ff <= data_i[3:0];
		end
	end
	// Read answer mixes latched upper bits with the low address
	assign data_o = {upper_ff, addr_i[3:0]};
endmodule : bpm_card
`default_nettype wire

// >>> verification/test_backplane_master_bus_interface.sv
// Testbench: directed scenarios for the backplane master
`timescale 1ns/1ps
`default_nettype none
module test_backplane_master_bus_interface;
	import bpm_pkg::*;
	logic SYS_CLK_I, RST_I, REQ_VALID_I, MEM_WR_N_I, REMAP_EN_I, SUPPLY_OK_I, WDOG_EN_I;
	logic CNT2_OUT_I, STANDBY_REQ_I, SYSRESET_N_I, INTRQ_N_I, NMIRQ_N_I, REQ_READY_O, DONE_O;
	logic BP_DATA_OE_O, MCSYNC_N_O, IOEXP_N_O, MEMEX_OE_O, MEM_WR_N_O, SOCK0_SEL_O;
	logic SOCK1_SEL_O, ONB_IO_SEL_O, PBRESET_N_O, STANDBY_O;
	cpu_req_s REQ_I;
	dec_win_s SOCK0_WIN_I, SOCK1_WIN_I;
	logic [2:0] CASC_ADDR_I;
	logic [7:0] RDATA_O, BP_DATA_I, BP_DATA_O, ONB_IRQ_I, PIC_IRQ_O, card_q;
	logic [15:0] BP_ADDR_O, seen_addr;
	logic [4:0] FRONT_IRQ_I;
	logic [3:0] seen_flags;
	logic [IRQ_N-1:0][2:0] IRQ_ROUTE_I;
	int failures = 0, n_checks = 0, cyc_cnt = 0;
	bpm_master dut_u (.SYS_CLK_I, .RST_I, .REQ_VALID_I, .REQ_I, .CASC_ADDR_I, .MEM_WR_N_I,
		.REQ_READY_O, .RDATA_O, .DONE_O, .BP_ADDR_O, .BP_DATA_I, .BP_DATA_O, .BP_DATA_OE_O,
		.MCSYNC_N_O, .IOEXP_N_O, .MEMEX_OE_O, .MEM_WR_N_O, .SOCK0_WIN_I, .SOCK1_WIN_I,
		.REMAP_EN_I, .SOCK0_SEL_O, .SOCK1_SEL_O, .ONB_IO_SEL_O, .SUPPLY_OK_I, .WDOG_EN_I,
		.CNT2_OUT_I, .STANDBY_REQ_I, .SYSRESET_N_I, .INTRQ_N_I, .NMIRQ_N_I, .PBRESET_N_O,
		.STANDBY_O, .FRONT_IRQ_I, .IRQ_ROUTE_I, .ONB_IRQ_I, .PIC_IRQ_O);
	bpm_card card_u (.clk_i(SYS_CLK_I), .mcsync_n_i(MCSYNC_N_O), .addr_i(BP_ADDR_O),
		.data_i(BP_DATA_I), .data_o(card_q));
	// Wire level: master wins while it drives
	assign BP_DATA_I = BP_DATA_OE_O ? BP_DATA_O : card_q;
	//////////////////////////////
	// 200 MHz clock and hang guard
	initial begin
		SYS_CLK_I = 1'b0;
		forever #2.5 SYS_CLK_I = ~SYS_CLK_I;
	end
	always @(posedge SYS_CLK_I) begin
		cyc_cnt++;
		if (cyc_cnt == 4000) begin
			failures++;
			end_sim();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic settle();
		repeat (4) @(negedge SYS_CLK_I);
	endtask : settle
	// One request held until taken, then wait for completion
	task automatic bus(input cyc_kind_e k, input cyc_type_e t, input logic [19:0] a);
		int w;
		w = 0;
		@(posedge SYS_CLK_I);
		REQ_VALID_I <= 1'b1;
		REQ_I <= '{a, k, t, 8'hC3};
		@(negedge SYS_CLK_I);
		while (REQ_READY_O !== 1'b1 && w < 50) begin
			@(negedge SYS_CLK_I);
			w++;
		end
		@(posedge SYS_CLK_I);
		REQ_VALID_I <= 1'b0;
		@(negedge SYS_CLK_I);
		seen_addr = BP_ADDR_O;
		seen_flags = {SOCK0_SEL_O, SOCK1_SEL_O, ONB_IO_SEL_O, IOEXP_N_O};
		while (DONE_O !== 1'b1 && w < 60) begin
			@(negedge SYS_CLK_I);
			w++;
		end
		chk(w < 60, 1'b1);
	endtask : bus
	//////////////////////////////
	task automatic t_mem();
		bus(CYC_MEM_RD, CYC_NORMAL, 20'hF1234);
		chk(seen_addr, 16'h1234);
		chk(RDATA_O, 8'hF4);
		chk(seen_flags[3:2], 2'b10);
		bus(CYC_MEM_WR, CYC_NORMAL, 20'h00010);
		chk(seen_flags[3:2], 2'b01);
		chk(MEMEX_OE_O, 1'b0);
		// Option windows swapped: top of memory now falls in socket 1
		@(posedge SYS_CLK_I);
		REMAP_EN_I <= 1'b1;
		SOCK0_WIN_I <= '{20'h00000, 20'hF0000};
		SOCK1_WIN_I <= '{20'hF0000, 20'hF0000};
		bus(CYC_MEM_RD, CYC_NORMAL, 20'hF1234);
		chk(seen_flags[3:2], 2'b01);
		chk(RDATA_O, 8'hF4);
		@(posedge SYS_CLK_I);
		REMAP_EN_I <= 1'b0;
		$display("memory test done");
	endtask : t_mem
	task automatic t_io();
		logic [15:0] pa [5] = '{16'h00FF, 16'hFF80, 16'h0080, 16'h00A7, 16'h00A8};
		foreach (pa[i]) begin
			bus(i[0] ? CYC_IO_WR : CYC_IO_RD, CYC_NORMAL, {4'h0, pa[i]});
			chk(seen_addr, pa[i]);
			chk(seen_flags[0], pa[i][8]);
			chk(seen_flags[1], pa[i] inside {[ONB_IO_LO:ONB_IO_HI]});
		end
		bus(CYC_IO_RD, CYC_INTA, 20'h00000);
		chk(seen_addr[10:8], 3'h5);
		$display("io test done");
	endtask : t_io
	// Supply fault then watchdog, both through the reset output
	task automatic t_reset();
		@(posedge SYS_CLK_I);
		SUPPLY_OK_I <= 1'b0;
		MEM_WR_N_I <= 1'b0;
		settle();
		chk(MEM_WR_N_O, 1'b1);
		chk(PBRESET_N_O, 1'b0);
		@(posedge SYS_CLK_I);
		SUPPLY_OK_I <= 1'b1;
		CNT2_OUT_I <= 1'b0;
		settle();
		chk(PBRESET_N_O, 1'b1);
		chk(MEM_WR_N_O, 1'b0);
		@(posedge SYS_CLK_I);
		WDOG_EN_I <= 1'b1;
		settle();
		chk(PBRESET_N_O, 1'b0);
		@(posedge SYS_CLK_I);
		CNT2_OUT_I <= 1'b1;
		MEM_WR_N_I <= 1'b1;
		settle();
		chk(PBRESET_N_O, 1'b1);
		$display("reset test done");
	endtask : t_reset
	task automatic t_sleep();
		for (int s = 0; s < 3; s++) begin
			@(posedge SYS_CLK_I);
			STANDBY_REQ_I <= 1'b1;
			settle();
			chk(REQ_READY_O, 1'b0);
			@(posedge SYS_CLK_I);
			STANDBY_REQ_I <= 1'b0;
			settle();
			chk(STANDBY_O, 1'b1);
			@(posedge SYS_CLK_I);
			{SYSRESET_N_I, INTRQ_N_I, NMIRQ_N_I} <= ~(3'h1 << s);
			settle();
			chk(STANDBY_O, 1'b0);
			@(posedge SYS_CLK_I);
			{SYSRESET_N_I, INTRQ_N_I, NMIRQ_N_I} <= 3'h7;
			settle();
		end
		$display("standby test done");
	endtask : t_sleep
	task automatic t_irq();
		@(posedge SYS_CLK_I);
		FRONT_IRQ_I <= 5'h10;
		settle();
		chk(PIC_IRQ_O, 8'h08);
		$display("interrupt test done");
	endtask : t_irq
	task automatic end_sim();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_sim
	// Reset, then the scenarios in turn
	initial begin
		{RST_I, MEM_WR_N_I, SUPPLY_OK_I, CNT2_OUT_I, SYSRESET_N_I, INTRQ_N_I, NMIRQ_N_I} = '1;
		{REQ_VALID_I, REMAP_EN_I, WDOG_EN_I, STANDBY_REQ_I} = '0;
		{REQ_I, SOCK0_WIN_I, SOCK1_WIN_I, FRONT_IRQ_I, ONB_IRQ_I} = '0;
		CASC_ADDR_I = 3'h5;
		foreach (IRQ_ROUTE_I[i]) IRQ_ROUTE_I[i] = 3'(7 - i);
		repeat (4) @(posedge SYS_CLK_I);
		RST_I <= 1'b0;
		settle();
		t_mem();
		t_io();
		t_reset();
		t_sleep();
		t_irq();
		end_sim();
	end
endmodule : test_backplane_master_bus_interface
bind bpm_master bpm_master_chk chk_u (.SYS_CLK_I, .RST_I, .REQ_VALID_I, .REQ_READY_O,
	.MCSYNC_N_O, .DONE_O, .IOEXP_N_O, .MEM_WR_N_O, .BP_DATA_OE_O, .ONB_IO_SEL_O,
	.SUPPLY_OK_I, .REQ_I, .CASC_ADDR_I, .BP_ADDR_O, .BP_DATA_O);
`default_nettype wire
